// >>> core/drive_param_pkg.sv
package drive_param_pkg;
  // parameter addresses (16-bit register units; odd ones exist, so these are indices)
  localparam logic [15:0] CHANNEL_LOCK_CTRL_IDX     = 16'h013C;
  localparam logic [15:0] USER_SCRATCH_4_IDX        = 16'h0144;
  localparam logic [15:0] ABS_MOVE_HOMING_GATE_IDX  = 16'h062C;
  localparam logic [15:0] BRAKE_MANUAL_CTRL_IDX     = 16'h0814;
  localparam logic [15:0] BRAKE_STATE_INFO_IDX      = 16'h0816;
  localparam logic [15:0] CAPTURE_A_EDGE_CFG_IDX    = 16'h0A04;
  localparam logic [15:0] CAPTURE_A_ARM_CTRL_IDX    = 16'h0A08;
  localparam logic [15:0] CAPTURE_A_EVENT_COUNT_IDX = 16'h0A10;
  localparam logic [15:0] WARNING_ACTIVE_WORD_IDX   = 16'h1C16;
  localparam logic [15:0] WARNING_LATCHED_WORD_IDX  = 16'h1C18;
  localparam logic [15:0] DC_BUS_UTILIZATION_IDX    = 16'h1E26;
  localparam logic [15:0] CAPTURE_A_POSITION_IDX    = 16'h0A0C;
  localparam logic [15:0] CAPTURE_FLAGS_IDX         = 16'h0A02;
  // reset values
  localparam logic [31:0] USER_SCRATCH_RST = 32'h0000_0000;
  localparam logic [15:0] CTRL_RST         = 16'h0000;
  // warning bit positions
  localparam int WARN_GENERAL     = 0;
  localparam int WARN_STAGE_TEMP  = 1;
  localparam int WARN_MOTOR_TEMP  = 2;
  localparam int WARN_RSVD3       = 3;
  localparam int WARN_STAGE_OVL   = 4;
  localparam int WARN_MOTOR_OVL   = 5;
  localparam int WARN_BRAKE_R_OVL = 6;
  localparam int WARN_CAN         = 7;
  localparam int WARN_ENCODER     = 8;
  localparam int WARN_RS485       = 9;
  localparam int WARN_STO         = 10;
  localparam int WARN_UNDERVOLT   = 11;
  localparam int WARN_POS_INVALID = 13;
  localparam int WARN_ETHERNET    = 14;
  localparam int WARN_RSVD15      = 15;
  localparam logic [15:0] WARN_USED_MASK  = 16'h6FF7;
  localparam logic [15:0] WARN_SELF_CLEAR = 16'h2C00;
  // codes
  localparam logic [1:0] ARM_STOP = 2'h0;
  localparam logic [1:0] ARM_ONCE = 2'h1;
  localparam logic [1:0] ARM_CONT = 2'h2;
  localparam logic [1:0] BRAKE_APPLIED  = 2'h0;
  localparam logic [1:0] BRAKE_RELEASED = 2'h1;
  localparam logic [1:0] BRAKE_ABSENT   = 2'h2;
  localparam int CAPTURE_FLAG_A = 0;
  typedef enum logic [1:0] {CAP_IDLE, CAP_ONCE, CAP_CONT} cap_state_e;
endpackage : drive_param_pkg

// >>> core/capture_unit.sv
`timescale 1ns/10ps
module capture_unit #(
  parameter int POS_W = 32,
  parameter int CNT_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rstSyncN,
  input  wire logic             captureAInput,
  input  wire logic             edgeRising,
  input  wire logic             armWrite,
  input  wire logic [1:0]       armCode,
  input  wire logic [POS_W-1:0] positionNow,
  input  wire logic             positionRebase,
  input  wire logic [POS_W-1:0] positionOffset,
  output logic                  captureBusy,
  output logic                  captureDone,
  output logic [POS_W-1:0]      capturedPos,
  output logic [CNT_W-1:0]      eventCount
);
  drive_param_pkg::cap_state_e state_reg;
  logic inMeta_reg;
  logic inSync_reg;
  logic inPrev_reg;
  logic hit;
  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      inMeta_reg <= 1'b0;
      inSync_reg <= 1'b0;
      inPrev_reg <= 1'b0;
    end else begin
      inMeta_reg <= captureAInput;
      inSync_reg <= inMeta_reg;
      inPrev_reg <= inSync_reg;
    end
  end
  assign hit = (state_reg != drive_param_pkg::CAP_IDLE) &&
               (edgeRising ? (inSync_reg & ~inPrev_reg) : (~inSync_reg & inPrev_reg));
  assign captureBusy = (state_reg != drive_param_pkg::CAP_IDLE);
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= drive_param_pkg::CAP_IDLE;
    end else if (armWrite) begin
      case (armCode)
        drive_param_pkg::ARM_ONCE: state_reg <= drive_param_pkg::CAP_ONCE;
        drive_param_pkg::ARM_CONT: state_reg <= drive_param_pkg::CAP_CONT;
        default:                   state_reg <= drive_param_pkg::CAP_IDLE;
      endcase
    end else begin
      case (state_reg)
        drive_param_pkg::CAP_ONCE: if (hit) state_reg <= drive_param_pkg::CAP_IDLE;
        drive_param_pkg::CAP_CONT: state_reg <= drive_param_pkg::CAP_CONT;
        default:                   state_reg <= drive_param_pkg::CAP_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      eventCount <= '0;
    end else if (armWrite && armCode != drive_param_pkg::ARM_STOP) begin
      eventCount <= '0;
    end else if (hit) begin
      eventCount <= eventCount + 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      capturedPos <= '0;
      captureDone <= 1'b0;
    end else begin
      // rebase shifts a stored value into the new position frame
      if (hit) begin
        capturedPos <= positionNow;
      end else if (positionRebase) begin
        capturedPos <= capturedPos + positionOffset;
      end
      // set wins over re-arm clear
      if (hit) begin
        captureDone <= 1'b1;
      end else if (armWrite && armCode != drive_param_pkg::ARM_STOP) begin
        captureDone <= 1'b0;
      end
    end
  end
endmodule : capture_unit

// >>> core/drive_warning_brake_capture_params.sv
`timescale 1ns/10ps
module drive_warning_brake_capture_params #(
  parameter int POS_W = 32,
  parameter int CNT_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // parameter access port from the fieldbus stack
  input  wire logic             paramWrite,
  input  wire logic             paramRead,
  input  wire logic [15:0]      paramIndex,
  input  wire logic [31:0]      paramWdata,
  output logic [31:0]           paramRdata,
  output logic                  paramRvalid,
  output logic                  paramError,
  // drive state
  input  wire logic [15:0]      warningCauses,
  input  wire logic             faultReset,
  input  wire logic             powerStageEnable,
  input  wire logic             stateSwitchOnDisabled,
  input  wire logic             stateReadyToSwitchOn,
  input  wire logic             brakeFitted,
  input  wire logic             brakeAutoRelease,
  input  wire logic             homingDone,
  input  wire logic             absMoveRequest,
  input  wire logic             ioCtrlRequest,
  input  wire logic             toolCtrlRequest,
  input  wire logic             holdMotionInput,
  input  wire logic signed [15:0] dcBusUtilPercent,
  input  wire logic             captureAInput,
  input  wire logic [POS_W-1:0] positionNow,
  input  wire logic             positionRebase,
  input  wire logic [POS_W-1:0] positionOffset,
  output logic                  absMoveGrant,
  output logic                  ioCtrlGrant,
  output logic                  toolCtrlGrant,
  output logic                  holdMotion,
  output logic                  brakeReleaseCmd,
  output logic [1:0]            brakeState,
  output logic                  captureBusy
);
  logic rstMeta_reg;
  logic rstSyncN;
  logic [15:0] warning_active_word_reg;
  logic [15:0] warning_latched_word_reg;
  logic [15:0] warning_latched_word_next;
  logic [31:0] userScratch_reg;
  logic        homingGate_reg;
  logic        channelLock_reg;
  logic        brakeManual_reg;
  logic        edgeRising_reg;
  logic [1:0]  armCode_reg;
  logic signed [15:0] dcUtil_reg;
  logic        armWrite;
  logic        captureDone;
  logic [POS_W-1:0] capturedPos;
  logic [CNT_W-1:0] eventCount;
  logic        manualAllowed;

  function automatic logic isWrite(input logic [15:0] idx, input logic [15:0] target, input logic wr);
    isWrite = wr && (idx == target);
  endfunction : isWrite

  // async assert, clocked release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_reg <= 1'b0;
      rstSyncN    <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSyncN    <= rstMeta_reg;
    end
  end

  // warnings
  always_comb begin
    warning_latched_word_next = warning_latched_word_reg | (warningCauses & drive_param_pkg::WARN_USED_MASK);
    // self-clearing bits follow their live cause
    warning_latched_word_next = (warning_latched_word_next & ~drive_param_pkg::WARN_SELF_CLEAR) |
                       (warningCauses & drive_param_pkg::WARN_SELF_CLEAR);
    if (faultReset) begin
      // old bits go, but a cause seen in the reset cycle still latches
      warning_latched_word_next = warningCauses & drive_param_pkg::WARN_USED_MASK;
    end
  end
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      warning_active_word_reg  <= drive_param_pkg::CTRL_RST;
      warning_latched_word_reg <= drive_param_pkg::CTRL_RST;
      dcUtil_reg      <= '0;
    end else begin
      warning_active_word_reg  <= warningCauses & drive_param_pkg::WARN_USED_MASK;
      warning_latched_word_reg <= warning_latched_word_next;
      dcUtil_reg      <= dcBusUtilPercent;
    end
  end

  // plain parameters
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      userScratch_reg <= drive_param_pkg::USER_SCRATCH_RST;
      homingGate_reg  <= 1'b0;
      channelLock_reg <= 1'b0;
      edgeRising_reg  <= 1'b0;
      armCode_reg     <= drive_param_pkg::ARM_STOP;
    end else begin
      if (isWrite(paramIndex, drive_param_pkg::USER_SCRATCH_4_IDX, paramWrite))
        userScratch_reg <= paramWdata;
      if (isWrite(paramIndex, drive_param_pkg::ABS_MOVE_HOMING_GATE_IDX, paramWrite) && paramWdata[15:1] == '0)
        homingGate_reg <= paramWdata[0];
      if (isWrite(paramIndex, drive_param_pkg::CHANNEL_LOCK_CTRL_IDX, paramWrite) && paramWdata[15:1] == '0)
        channelLock_reg <= paramWdata[0];
      if (isWrite(paramIndex, drive_param_pkg::CAPTURE_A_EDGE_CFG_IDX, paramWrite) && paramWdata[15:1] == '0)
        edgeRising_reg <= paramWdata[0];
      if (armWrite)
        armCode_reg <= paramWdata[1:0];
    end
  end
  assign armWrite = isWrite(paramIndex, drive_param_pkg::CAPTURE_A_ARM_CTRL_IDX, paramWrite) &&
                    paramWdata[15:0] <= 16'h0002;

  // brake
  assign manualAllowed = stateSwitchOnDisabled | stateReadyToSwitchOn;
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      brakeManual_reg <= 1'b0;
    end else if (powerStageEnable) begin
      brakeManual_reg <= 1'b0;
    end else if (isWrite(paramIndex, drive_param_pkg::BRAKE_MANUAL_CTRL_IDX, paramWrite) &&
                 paramWdata[15:1] == '0) begin
      brakeManual_reg <= paramWdata[0];
    end
  end
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      brakeReleaseCmd <= 1'b0;
      brakeState      <= drive_param_pkg::BRAKE_APPLIED;
    end else begin
      brakeReleaseCmd <= brakeFitted & ((brakeManual_reg & manualAllowed) | (~brakeManual_reg & brakeAutoRelease));
      if (!brakeFitted)
        brakeState <= drive_param_pkg::BRAKE_ABSENT;
      else if (brakeReleaseCmd)
        brakeState <= drive_param_pkg::BRAKE_RELEASED;
      else
        brakeState <= drive_param_pkg::BRAKE_APPLIED;
    end
  end

  // gates are handshakes, so combinational
  assign absMoveGrant  = absMoveRequest & (~homingGate_reg | homingDone);
  assign ioCtrlGrant   = ioCtrlRequest & ~channelLock_reg;
  assign toolCtrlGrant = toolCtrlRequest & ~channelLock_reg;
  assign holdMotion    = holdMotionInput;

  capture_unit #(
    .POS_W (POS_W),
    .CNT_W (CNT_W)
  ) u_capture (
    .sys_clk        (sys_clk),
    .rstSyncN       (rstSyncN),
    .captureAInput  (captureAInput),
    .edgeRising     (edgeRising_reg),
    .armWrite       (armWrite),
    .armCode        (paramWdata[1:0]),
    .positionNow    (positionNow),
    .positionRebase (positionRebase),
    .positionOffset (positionOffset),
    .captureBusy    (captureBusy),
    .captureDone    (captureDone),
    .capturedPos    (capturedPos),
    .eventCount     (eventCount)
  );

  // read port: one cycle after paramRead
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      paramRdata  <= '0;
      paramRvalid <= 1'b0;
      paramError  <= 1'b0;
    end else begin
      paramRvalid <= paramRead;
      paramError  <= 1'b0;
      paramRdata  <= '0;
      if (paramRead) begin
        case (paramIndex)
          drive_param_pkg::CHANNEL_LOCK_CTRL_IDX:     paramRdata <= {31'h0, channelLock_reg};
          drive_param_pkg::USER_SCRATCH_4_IDX:        paramRdata <= userScratch_reg;
          drive_param_pkg::ABS_MOVE_HOMING_GATE_IDX:  paramRdata <= {31'h0, homingGate_reg};
          drive_param_pkg::BRAKE_MANUAL_CTRL_IDX:     paramRdata <= {31'h0, brakeManual_reg};
          drive_param_pkg::BRAKE_STATE_INFO_IDX:      paramRdata <= {30'h0, brakeState};
          drive_param_pkg::CAPTURE_A_EDGE_CFG_IDX:    paramRdata <= {31'h0, edgeRising_reg};
          drive_param_pkg::CAPTURE_A_ARM_CTRL_IDX:    paramRdata <= {30'h0, armCode_reg};
          drive_param_pkg::CAPTURE_A_EVENT_COUNT_IDX: paramRdata <= 32'(eventCount);
          drive_param_pkg::CAPTURE_A_POSITION_IDX:    paramRdata <= 32'(capturedPos);
          drive_param_pkg::CAPTURE_FLAGS_IDX:         paramRdata <= {31'h0, captureDone};
          drive_param_pkg::WARNING_ACTIVE_WORD_IDX:   paramRdata <= {16'h0, warning_active_word_reg};
          drive_param_pkg::WARNING_LATCHED_WORD_IDX:  paramRdata <= {16'h0, warning_latched_word_reg};
          drive_param_pkg::DC_BUS_UTILIZATION_IDX:    paramRdata <= 32'(dcUtil_reg);
          default:                                    paramError <= 1'b1;
        endcase
      end
    end
  end
endmodule : drive_warning_brake_capture_params

// >>> dv/fieldbus_master_model.sv
`timescale 1ns/10ps
module fieldbus_master_model (
  input  wire logic        sys_clk,
  output logic             paramWrite,
  output logic             paramRead,
  output logic [15:0]      paramIndex,
  output logic [31:0]      paramWdata,
  input  wire logic [31:0] paramRdata,
  input  wire logic        paramRvalid
);
  initial begin
    paramWrite = 1'b0;
    paramRead  = 1'b0;
    paramIndex = 16'h0000;
    paramWdata = 32'h0000_0000;
  end
  // released fields are inverted so a stale value never reads as a hit
  task automatic wr(input logic [15:0] idx, input logic [31:0] data);
    @(posedge sys_clk);
    paramWrite <= 1'b1;
    paramIndex <= idx;
    paramWdata <= data;
    @(posedge sys_clk);
    paramWrite <= 1'b0;
    paramIndex <= ~idx;
    paramWdata <= ~data;
  endtask : wr
  task automatic rd(input logic [15:0] idx, output logic [31:0] data, output logic ok);
    ok = 1'b0;
    @(posedge sys_clk);
    paramRead  <= 1'b1;
    paramIndex <= idx;
    @(posedge sys_clk);
    paramRead  <= 1'b0;
    paramIndex <= ~idx;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok   = paramRvalid === 1'b1;
      data = paramRdata;
      if (!ok) @(posedge sys_clk);
    end
  endtask : rd
endmodule : fieldbus_master_model

// >>> dv/drive_params_asserts.sv
`timescale 1ns/10ps
module drive_params_asserts (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        paramWrite,
  input wire logic        paramRead,
  input wire logic [15:0] paramIndex,
  input wire logic [31:0] paramWdata,
  input wire logic        paramRvalid,
  input wire logic        paramError,
  input wire logic        homingDone,
  input wire logic        absMoveRequest,
  input wire logic        absMoveGrant,
  input wire logic        ioCtrlRequest,
  input wire logic        ioCtrlGrant,
  input wire logic        holdMotionInput,
  input wire logic        holdMotion,
  input wire logic        brakeFitted,
  input wire logic [1:0]  brakeState,
  input wire logic        captureBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic armWrite;
  assign armWrite = paramWrite && paramIndex == drive_param_pkg::CAPTURE_A_ARM_CTRL_IDX;
  AST_READ_ANSWER: assert property (paramRead |=> paramRvalid) else $error("read unanswered");
  AST_UNMAPPED_READ: assert property (paramRead && paramIndex == 16'h0000 |=> paramError) else $error("no error flag");
  AST_ABS_HOMED: assert property (absMoveRequest && homingDone |-> absMoveGrant) else $error("abs move refused");
  AST_ABS_NO_REQ: assert property (!absMoveRequest |-> !absMoveGrant) else $error("abs grant unasked");
  AST_IO_NEEDS_REQ: assert property (ioCtrlGrant |-> ioCtrlRequest) else $error("io grant unasked");
  AST_HOLD_ALWAYS: assert property (holdMotion == holdMotionInput) else $error("hold input lost");
  // four cycles cover the reset synchroniser plus the registered state
  AST_BRAKE_ABSENT: assert property ((!brakeFitted) [*4] |-> brakeState == drive_param_pkg::BRAKE_ABSENT)
    else $error("brake absent not shown");
  AST_ARM_STOP: assert property (armWrite && paramWdata == 32'h0 |=> !captureBusy) else $error("cancel ignored");
  AST_ARM_START: assert property (armWrite && (paramWdata == 32'h1 || paramWdata == 32'h2) |=> captureBusy)
    else $error("arm ignored");
endmodule : drive_params_asserts
bind drive_warning_brake_capture_params drive_params_asserts CHK (.sys_clk(sys_clk), .reset_n(reset_n),
  .paramWrite(paramWrite), .paramRead(paramRead), .paramIndex(paramIndex), .paramWdata(paramWdata),
  .paramRvalid(paramRvalid), .paramError(paramError), .homingDone(homingDone), .absMoveRequest(absMoveRequest),
  .absMoveGrant(absMoveGrant), .ioCtrlRequest(ioCtrlRequest), .ioCtrlGrant(ioCtrlGrant),
  .holdMotionInput(holdMotionInput), .holdMotion(holdMotion), .brakeFitted(brakeFitted),
  .brakeState(brakeState), .captureBusy(captureBusy));

// >>> dv/drive_warning_brake_capture_params_tb.sv
`timescale 1ns/10ps
module drive_warning_brake_capture_params_tb;
  logic               sys_clk = 1'b0, reset_n = 1'b0;
  logic               paramWrite, paramRead, paramRvalid, paramError;
  logic [15:0]        paramIndex, warningCauses = 16'h0000;
  logic [31:0]        paramWdata, paramRdata;
  logic               faultReset = 1'b0, powerStageEnable = 1'b0, stateSwitchOnDisabled = 1'b1;
  logic               stateReadyToSwitchOn = 1'b0, brakeFitted = 1'b1, homingDone = 1'b0;
  logic               absMoveRequest = 1'b0, ioCtrlRequest = 1'b0, toolCtrlRequest = 1'b0;
  logic               holdMotionInput = 1'b0, captureAInput = 1'b0, positionRebase = 1'b0;
  logic               brakeAutoRelease = 1'b0;
  logic signed [15:0] dcBusUtilPercent = 16'sh0000;
  logic [31:0]        positionNow = 32'h0001_2340, positionOffset = 32'h0000_0100;
  logic               absMoveGrant, ioCtrlGrant, toolCtrlGrant, holdMotion, brakeReleaseCmd, captureBusy;
  logic [1:0]         brakeState;
  int                 err_total = 0, comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  fieldbus_master_model MST (.sys_clk(sys_clk), .paramWrite(paramWrite), .paramRead(paramRead),
    .paramIndex(paramIndex), .paramWdata(paramWdata), .paramRdata(paramRdata), .paramRvalid(paramRvalid));
  drive_warning_brake_capture_params #(.POS_W(32), .CNT_W(16)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .paramWrite(paramWrite), .paramRead(paramRead), .paramIndex(paramIndex), .paramWdata(paramWdata),
    .paramRdata(paramRdata), .paramRvalid(paramRvalid), .paramError(paramError), .warningCauses(warningCauses),
    .faultReset(faultReset), .powerStageEnable(powerStageEnable), .stateSwitchOnDisabled(stateSwitchOnDisabled),
    .stateReadyToSwitchOn(stateReadyToSwitchOn), .brakeFitted(brakeFitted), .brakeAutoRelease(brakeAutoRelease),
    .homingDone(homingDone), .absMoveRequest(absMoveRequest), .ioCtrlRequest(ioCtrlRequest),
    .toolCtrlRequest(toolCtrlRequest), .holdMotionInput(holdMotionInput), .dcBusUtilPercent(dcBusUtilPercent),
    .captureAInput(captureAInput), .positionNow(positionNow), .positionRebase(positionRebase),
    .positionOffset(positionOffset), .absMoveGrant(absMoveGrant), .ioCtrlGrant(ioCtrlGrant),
    .toolCtrlGrant(toolCtrlGrant), .holdMotion(holdMotion), .brakeReleaseCmd(brakeReleaseCmd),
    .brakeState(brakeState), .captureBusy(captureBusy));
  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : chkb
  task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp,
                       input logic [31:0] mask = 32'h0000_FFFF);
    logic [31:0] d;
    logic        ok;
    MST.rd(idx, d, ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error %s expected answer seen none", what);
      end_sim();
    end else begin
      chk(what, exp & mask, d & mask);
    end
  endtask : rdchk
  task automatic cap_pulse();
    @(posedge sys_clk) captureAInput <= 1'b1;
    repeat (6) @(posedge sys_clk);
    captureAInput <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : cap_pulse
  task automatic t_regs();
    rdchk("scratch rst", drive_param_pkg::USER_SCRATCH_4_IDX, 32'h0, 32'hFFFF_FFFF);
    rdchk("gate rst", drive_param_pkg::ABS_MOVE_HOMING_GATE_IDX, 32'h0);
    MST.wr(drive_param_pkg::USER_SCRATCH_4_IDX, 32'hA5C3_0F96);
    rdchk("scratch", drive_param_pkg::USER_SCRATCH_4_IDX, 32'hA5C3_0F96, 32'hFFFF_FFFF);
    chkb("mapped err", 1'b0, paramError);
    MST.wr(drive_param_pkg::BRAKE_STATE_INFO_IDX, 32'h2);
    rdchk("brake ro", drive_param_pkg::BRAKE_STATE_INFO_IDX, 32'h0);
    rdchk("unmapped", 16'h0000, 32'h0, 32'hFFFF_FFFF);
    chkb("unmapped err", 1'b1, paramError);
    @(posedge sys_clk) dcBusUtilPercent <= 16'shFFE7;
    rdchk("util", drive_param_pkg::DC_BUS_UTILIZATION_IDX, 32'hFFE7);
  endtask : t_regs
  task automatic t_warn();
    // bit 12 is treated as unused by this block
    for (int b = 0; b < 16; b++) begin
      @(posedge sys_clk) warningCauses <= 16'h0001 << b;
      rdchk("warn bit", drive_param_pkg::WARNING_ACTIVE_WORD_IDX, (32'h1 << b) & 32'h6FF7);
    end
    @(posedge sys_clk) warningCauses <= 16'h0000;
    rdchk("latched", drive_param_pkg::WARNING_LATCHED_WORD_IDX, 32'h43F7);
    @(posedge sys_clk) faultReset <= 1'b1;
    @(posedge sys_clk) faultReset <= 1'b0;
    rdchk("latched clr", drive_param_pkg::WARNING_LATCHED_WORD_IDX, 32'h0);
  endtask : t_warn
  task automatic t_gate_lock();
    @(posedge sys_clk) absMoveRequest <= 1'b1;
    MST.wr(drive_param_pkg::ABS_MOVE_HOMING_GATE_IDX, 32'h1);
    #1 chkb("abs gated", 1'b0, absMoveGrant);
    @(posedge sys_clk) homingDone <= 1'b1;
    #1 chkb("abs homed", 1'b1, absMoveGrant);
    @(posedge sys_clk) homingDone <= 1'b0;
    MST.wr(drive_param_pkg::ABS_MOVE_HOMING_GATE_IDX, 32'h0);
    #1 chkb("abs free", 1'b1, absMoveGrant);
    @(posedge sys_clk) ioCtrlRequest <= 1'b1;
    toolCtrlRequest <= 1'b1;
    MST.wr(drive_param_pkg::CHANNEL_LOCK_CTRL_IDX, 32'h1);
    holdMotionInput <= 1'b1;
    #1 chkb("io locked", 1'b0, ioCtrlGrant);
    chkb("tool locked", 1'b0, toolCtrlGrant);
    chkb("hold", 1'b1, holdMotion);
    MST.wr(drive_param_pkg::CHANNEL_LOCK_CTRL_IDX, 32'h0);
    #1 chkb("io free", 1'b1, ioCtrlGrant);
    chkb("tool free", 1'b1, toolCtrlGrant);
  endtask : t_gate_lock
  task automatic t_brake();
    MST.wr(drive_param_pkg::BRAKE_MANUAL_CTRL_IDX, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chkb("release", 1'b1, brakeReleaseCmd);
    chk("brake open", 32'h1, {30'h0, brakeState});
    @(posedge sys_clk) stateSwitchOnDisabled <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chkb("no release", 1'b0, brakeReleaseCmd);
    chk("brake shut", 32'h0, {30'h0, brakeState});
    @(posedge sys_clk) stateReadyToSwitchOn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chkb("release rdy", 1'b1, brakeReleaseCmd);
    @(posedge sys_clk) powerStageEnable <= 1'b1;
    @(posedge sys_clk) powerStageEnable <= 1'b0;
    rdchk("brake forced", drive_param_pkg::BRAKE_MANUAL_CTRL_IDX, 32'h0);
    @(posedge sys_clk) brakeAutoRelease <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chkb("auto release", 1'b1, brakeReleaseCmd);
    @(posedge sys_clk) brakeAutoRelease <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chkb("auto applied", 1'b0, brakeReleaseCmd);
    @(posedge sys_clk) brakeFitted <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk("brake none", 32'h2, {30'h0, brakeState});
  endtask : t_brake
  task automatic t_capture();
    MST.wr(drive_param_pkg::CAPTURE_A_ARM_CTRL_IDX, 32'h1);
    #1 chkb("armed", 1'b1, captureBusy);
    cap_pulse();
    cap_pulse();
    rdchk("once cnt", drive_param_pkg::CAPTURE_A_EVENT_COUNT_IDX, 32'h1);
    chkb("once done", 1'b0, captureBusy);
    rdchk("flag", drive_param_pkg::CAPTURE_FLAGS_IDX, 32'h1, 32'h1);
    rdchk("pos", drive_param_pkg::CAPTURE_A_POSITION_IDX, 32'h0001_2340, 32'hFFFF_FFFF);
    MST.wr(drive_param_pkg::CAPTURE_A_EDGE_CFG_IDX, 32'h1);
    MST.wr(drive_param_pkg::CAPTURE_A_ARM_CTRL_IDX, 32'h2);
    rdchk("cnt clr", drive_param_pkg::CAPTURE_A_EVENT_COUNT_IDX, 32'h0);
    repeat (3) cap_pulse();
    rdchk("cont cnt", drive_param_pkg::CAPTURE_A_EVENT_COUNT_IDX, 32'h3);
    @(posedge sys_clk) positionRebase <= 1'b1;
    @(posedge sys_clk) positionRebase <= 1'b0;
    rdchk("rebased", drive_param_pkg::CAPTURE_A_POSITION_IDX, 32'h0001_2440, 32'hFFFF_FFFF);
    MST.wr(drive_param_pkg::CAPTURE_A_ARM_CTRL_IDX, 32'h0);
    #1 chkb("stopped", 1'b0, captureBusy);
    cap_pulse();
    rdchk("stop cnt", drive_param_pkg::CAPTURE_A_EVENT_COUNT_IDX, 32'h3);
  endtask : t_capture
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_warn();
    t_gate_lock();
    t_brake();
    t_capture();
    end_sim();
  end
endmodule : drive_warning_brake_capture_params_tb
